// ==== core/dpc_map.vh ====
// Offsets, field positions, reset values and codes of the delay and probe config bank.
// Assumes inclusion by bare name from the core files.
`ifndef DPC_MAP_VH
`define DPC_MAP_VH
// ********************************
// Register offsets
// ********************************
`define DPC_OFS_MISC        8'hE8
`define DPC_OFS_DLY_A       8'hE9
`define DPC_OFS_DLY_B       8'hEA
`define DPC_OFS_DLY_F       8'hEB
`define DPC_OFS_DLY_V       8'hEC
`define DPC_OFS_DLY_I2      8'hED
`define DPC_OFS_DLY_I4      8'hEE
`define DPC_OFS_RSVD        8'hEF
`define DPC_OFS_PMODE       8'hF0
`define DPC_OFS_PGRP        8'hF1
`define DPC_OFS_PSWAP       8'hF2
`define DPC_OFS_PCNT        8'hF3
`define DPC_OFS_FIRST       8'hE8
`define DPC_NUM_BYTES       12
// ********************************
// Field positions in misc_settings
// ********************************
`define DPC_MISC_DLY_EN     0
`define DPC_MISC_TMR_LO     1
`define DPC_MISC_TMR_HI     2
`define DPC_MISC_REG_OUT    3
`define DPC_MISC_TRIM_SUM   4
`define DPC_MISC_MASK       8'h1F
// ********************************
// Codes, reset values and trim bit positions
// ********************************
`define DPC_MODE_ANALOG     8'h01
`define DPC_MODE_DIGITAL    8'h02
`define DPC_RST_BYTE        8'h00
`define DPC_TRIM_LSB        12
`define DPC_TRIM_MSB        19
`endif

// ==== core/dpc_scale.v ====
// Delay scaler: base delay shifted by a rate step of zero to three.
// Assumes a registered base and step from the same clock.
`timescale 1ns/1ps
`default_nettype none
module dpc_scale #(
    parameter W = 8
) (
    input  wire         CLOCK,
    input  wire         RESET_N,
    input  wire [W-1:0] BASE,
    input  wire [1:0]   STEP,
    input  wire         ENABLE,
    output reg  [W+2:0] DELAY
);
    // Registered shift, zero when delay is disabled
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            DELAY <= {(W+3){1'b0}};
        end else if (ENABLE) begin
            DELAY <= {3'b000, BASE} << STEP;
        end else begin
            DELAY <= {(W+3){1'b0}};
        end
    end
endmodule
`default_nettype wire

// ==== core/dpc_group_check.v ====
// Probe group code checker for the analog and digital valid lists.
// Assumes a combinational use by the bank on one clock.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.vh"
module dpc_group_check (
    input  wire [7:0] CODE,
    input  wire [7:0] MODE,
    output reg        VALID
);
    // Lookup of accepted codes per mode
    always @* begin
        VALID = 1'b0;
        if (MODE == `DPC_MODE_ANALOG) begin
            case (CODE)
                8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                8'h06, 8'h07, 8'h09, 8'h0A: VALID = 1'b1;
                default: VALID = 1'b0;
            endcase
        end else begin
            case (CODE)
                8'h00, 8'h01, 8'h10, 8'h1B, 8'h1D,
                8'h30, 8'h58, 8'h70, 8'h73, 8'hB9: VALID = 1'b1;
                default: VALID = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== core/dpc_bank.v ====
// Delay and probe configuration byte bank with derived control outputs.
// Assumes a same-clock register port and an external store image for start-up load.
//
// Operation
// (RULE_01) Bit 0 of misc settings turns the firmware receive delay off at 0 and on at 1.
// (RULE_02) With the delay on, each technology's per-rate delay comes from its stored base.
// (RULE_03) Misc bits 2 to 1 pick contactless timer 0, 1 or 2 with codes 00, 01 and 10.
// (RULE_04) Misc bit 3 switches the regulated output on or off.
// (RULE_05) Misc bit 4 set makes the AGC trim the stored trim plus system bits 19 to 12.
// (RULE_06) Type A base is the 848 delay, doubled at 424, times four at 212, eight at 106.
// (RULE_07) Type B uses the same base at 848 and the same doubling steps as type A.
// (RULE_08) Type F base is the 424 delay and twice the base is used at 212.
// (RULE_09) Vicinity base is the fast-high delay and twice the base is the high delay.
// (RULE_10) Each item-management variant uses its own base byte directly.
// (RULE_11) Probe mode value 1 selects analog output and value 2 digital output.
// (RULE_12) Probe group select accepts only the listed valid codes for the current mode; any mode value other than 1 is checked against the digital list.
// (RULE_13) Probe line swap 0 maps line zero onto line one, 1 maps line one onto zero.
// (RULE_14) The pad map count tells how many pad routing entries are valid.
// (RULE_15) A pad routing entry holds the pad in its upper nibble, bit in its lower nibble.
// (RULE_16) The bytes load from storage at start-up and bad group codes are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.vh"
module dpc_bank #(
    parameter DW       = 8,
    parameter MAX_PADS = 4
) (
    input  wire                CLOCK,
    input  wire                RESET_N,
    // Register port
    input  wire [7:0]          ADDR,
    input  wire [7:0]          WDATA,
    input  wire                WR,
    input  wire                RD,
    output reg  [7:0]          RDATA,
    // Start-up load from nonvolatile store
    input  wire                LOAD_VALID,
    input  wire [7:0]          LOAD_ADDR,
    input  wire [7:0]          LOAD_DATA,
    input  wire                LOAD_DONE,
    output reg                 READY,
    // Rate select per technology
    input  wire [1:0]          RATE_A,
    input  wire [1:0]          RATE_B,
    input  wire                RATE_F_SLOW,
    input  wire                RATE_V_HIGH,
    // Trim inputs
    input  wire [7:0]          TRIM_STORED,
    input  wire [31:0]         SYS_SETTINGS,
    // Pad routing entries
    input  wire [8*MAX_PADS-1:0] PAD_ENTRIES,
    // Derived controls
    output reg                 FW_RX_DELAY_ENABLE,
    output reg  [2:0]          TIMER_ONEHOT,
    output reg                 REGULATED_OUT,
    output reg  [7:0]          AGC_TRIM,
    output wire [DW+2:0]       DELAY_A,
    output wire [DW+2:0]       DELAY_B,
    output wire [DW+2:0]       DELAY_F,
    output wire [DW+2:0]       DELAY_V,
    output reg  [DW-1:0]       DELAY_I2,
    output reg  [DW-1:0]       DELAY_I4,
    output reg                 PROBE_MODE_ANALOG,
    output reg                 PROBE_MODE_DIGITAL,
    output reg  [7:0]          PROBE_GROUP,
    output reg                 PROBE_LINE_SWAP,
    output reg  [MAX_PADS-1:0] PAD_ENTRY_VALID,
    output reg  [4*MAX_PADS-1:0] PAD_LOCATION,
    output reg  [4*MAX_PADS-1:0] PAD_BIT
);
    // ********************************
    // Rate step encodings
    // ********************************
    // RATE_A and RATE_B: 0 for 848, 1 for 424, 2 for 212, 3 for 106 kbit/s
    // RATE_F_SLOW: 0 for 424, 1 for 212 kbit/s
    // RATE_V_HIGH: 0 for the fast-high rate, 1 for the high rate
    // Each step doubles the stored base, so a step is a left shift
    // Three spare output bits hold the largest shift without loss
    // Rate selects come from protocol logic on this clock, no sync

    // ********************************
    // Storage
    // ********************************
    // Stored bytes, one per offset
    reg  [7:0] misc_q;
    reg  [7:0] dly_a_q;
    reg  [7:0] dly_b_q;
    reg  [7:0] dly_f_q;
    reg  [7:0] dly_v_q;
    reg  [7:0] dly_i2_q;
    reg  [7:0] dly_i4_q;
    reg  [7:0] rsvd_q;
    reg  [7:0] pmode_q;
    reg  [7:0] pgrp_q;
    reg  [7:0] pswap_q;
    reg  [7:0] pcnt_q;

    // Write path and read mux
    reg  [7:0] rdata_d;
    reg        wr_en;
    reg  [7:0] wr_addr;
    reg  [7:0] wr_data;

    // Derived helpers
    wire       grp_ok;
    wire [7:0] grp_mode;
    wire [8:0] trim_sum;

    // Write source: store load until done, host port after
    // Host writes before ready are dropped, as are loads after it
    // Only one source drives the write path in any cycle
    always @* begin
        wr_en   = READY ? WR : LOAD_VALID;
        wr_addr = READY ? ADDR : LOAD_ADDR;
        wr_data = READY ? WDATA : LOAD_DATA;
    end

    // Mode already stored judges a group write
    // A mode written in the same cycle applies from the next group write
    assign grp_mode = pmode_q;

    // Valid-code screen for group writes
    dpc_group_check u_chk (
        .CODE  (wr_data),
        .MODE  (grp_mode),
        .VALID (grp_ok)
    );

    // Start-up load finish flag
    // Sticky until reset, it hands the write path to the host
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            READY <= 1'b0;
        end else if (LOAD_DONE) begin
            READY <= 1'b1; // RULE_16
        end
    end

    // ********************************
    // Byte writes
    // ********************************
    // Reset clears every byte; the store load fills them before ready
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            misc_q   <= `DPC_RST_BYTE;
            dly_a_q  <= `DPC_RST_BYTE;
            dly_b_q  <= `DPC_RST_BYTE;
            dly_f_q  <= `DPC_RST_BYTE;
            dly_v_q  <= `DPC_RST_BYTE;
            dly_i2_q <= `DPC_RST_BYTE;
            dly_i4_q <= `DPC_RST_BYTE;
            rsvd_q   <= `DPC_RST_BYTE;
            pmode_q  <= `DPC_RST_BYTE;
            pgrp_q   <= `DPC_RST_BYTE;
            pswap_q  <= `DPC_RST_BYTE;
            pcnt_q   <= `DPC_RST_BYTE;
        end else if (wr_en) begin
            case (wr_addr)
                // Misc settings, spare top bits kept as written
                `DPC_OFS_MISC:  misc_q   <= wr_data;
                // Delay base bytes and the reserved byte
                `DPC_OFS_DLY_A: dly_a_q  <= wr_data;
                `DPC_OFS_DLY_B: dly_b_q  <= wr_data;
                `DPC_OFS_DLY_F: dly_f_q  <= wr_data;
                `DPC_OFS_DLY_V: dly_v_q  <= wr_data;
                `DPC_OFS_DLY_I2: dly_i2_q <= wr_data;
                `DPC_OFS_DLY_I4: dly_i4_q <= wr_data;
                `DPC_OFS_RSVD:  rsvd_q   <= wr_data;
                // Probe setup bytes, group code screened first
                `DPC_OFS_PMODE: pmode_q  <= wr_data;
                `DPC_OFS_PGRP: begin
                    if (grp_ok) begin
                        pgrp_q <= wr_data; // RULE_12 RULE_16
                    end
                end
                `DPC_OFS_PSWAP: pswap_q  <= wr_data;
                `DPC_OFS_PCNT:  pcnt_q   <= wr_data;
                default: ;
            endcase
        end
    end

    // ********************************
    // Read port
    // ********************************
    // Decode on the live address; unmapped offsets read zero
    always @* begin
        case (ADDR)
            `DPC_OFS_MISC:   rdata_d = misc_q;
            `DPC_OFS_DLY_A:  rdata_d = dly_a_q;
            `DPC_OFS_DLY_B:  rdata_d = dly_b_q;
            `DPC_OFS_DLY_F:  rdata_d = dly_f_q;
            `DPC_OFS_DLY_V:  rdata_d = dly_v_q;
            `DPC_OFS_DLY_I2: rdata_d = dly_i2_q;
            `DPC_OFS_DLY_I4: rdata_d = dly_i4_q;
            `DPC_OFS_RSVD:   rdata_d = rsvd_q;
            `DPC_OFS_PMODE:  rdata_d = pmode_q;
            `DPC_OFS_PGRP:   rdata_d = pgrp_q;
            `DPC_OFS_PSWAP:  rdata_d = pswap_q;
            `DPC_OFS_PCNT:   rdata_d = pcnt_q;
            default:         rdata_d = 8'h00;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    // Zero between reads keeps a stale byte off the bus
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= rdata_d;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ********************************
    // Misc controls
    // ********************************
    // Trim sum wraps at eight bits, carry dropped
    assign trim_sum = {1'b0, TRIM_STORED} + {1'b0, SYS_SETTINGS[`DPC_TRIM_MSB:`DPC_TRIM_LSB]};

    // Misc outputs follow the stored byte one cycle later
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            FW_RX_DELAY_ENABLE <= 1'b0;
            TIMER_ONEHOT       <= 3'b001;
            REGULATED_OUT      <= 1'b0;
            AGC_TRIM           <= 8'h00;
        end else begin
            FW_RX_DELAY_ENABLE <= misc_q[`DPC_MISC_DLY_EN]; // RULE_01
            // Code 11 selects no timer
            case (misc_q[`DPC_MISC_TMR_HI:`DPC_MISC_TMR_LO])
                2'b00:   TIMER_ONEHOT <= 3'b001; // RULE_03
                2'b01:   TIMER_ONEHOT <= 3'b010; // RULE_03
                2'b10:   TIMER_ONEHOT <= 3'b100; // RULE_03
                default: TIMER_ONEHOT <= 3'b000;
            endcase
            REGULATED_OUT <= misc_q[`DPC_MISC_REG_OUT]; // RULE_04
            if (misc_q[`DPC_MISC_TRIM_SUM]) begin
                AGC_TRIM <= trim_sum[7:0]; // RULE_05
            end else begin
                AGC_TRIM <= TRIM_STORED;
            end
        end
    end

    // ********************************
    // Delay derivation
    // ********************************
    // Type A, four rates
    dpc_scale #(.W(DW)) u_sa (
        .CLOCK   (CLOCK),
        .RESET_N (RESET_N),
        .BASE    (dly_a_q),
        .STEP    (RATE_A),                   // RULE_06 RULE_02
        .ENABLE  (misc_q[`DPC_MISC_DLY_EN]),
        .DELAY   (DELAY_A)
    );

    // Type B, same steps as type A
    dpc_scale #(.W(DW)) u_sb (
        .CLOCK   (CLOCK),
        .RESET_N (RESET_N),
        .BASE    (dly_b_q),
        .STEP    (RATE_B),                   // RULE_07
        .ENABLE  (misc_q[`DPC_MISC_DLY_EN]),
        .DELAY   (DELAY_B)
    );

    // Type F, two rates
    dpc_scale #(.W(DW)) u_sf (
        .CLOCK   (CLOCK),
        .RESET_N (RESET_N),
        .BASE    (dly_f_q),
        .STEP    ({1'b0, RATE_F_SLOW}),      // RULE_08
        .ENABLE  (misc_q[`DPC_MISC_DLY_EN]),
        .DELAY   (DELAY_F)
    );

    // Vicinity protocol, two rates
    dpc_scale #(.W(DW)) u_sv (
        .CLOCK   (CLOCK),
        .RESET_N (RESET_N),
        .BASE    (dly_v_q),
        .STEP    ({1'b0, RATE_V_HIGH}),      // RULE_09
        .ENABLE  (misc_q[`DPC_MISC_DLY_EN]),
        .DELAY   (DELAY_V)
    );

    // Item-management variants, no scaling
    // Same enable as the scaled bases
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            DELAY_I2 <= {DW{1'b0}};
            DELAY_I4 <= {DW{1'b0}};
        end else if (misc_q[`DPC_MISC_DLY_EN]) begin
            DELAY_I2 <= dly_i2_q; // RULE_10
            DELAY_I4 <= dly_i4_q; // RULE_10
        end else begin
            DELAY_I2 <= {DW{1'b0}};
            DELAY_I4 <= {DW{1'b0}};
        end
    end

    // ********************************
    // Probe controls
    // ********************************
    // Mode flags, group and swap follow the stored bytes
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            PROBE_MODE_ANALOG  <= 1'b0;
            PROBE_MODE_DIGITAL <= 1'b0;
            PROBE_GROUP        <= 8'h00;
            PROBE_LINE_SWAP    <= 1'b0;
        end else begin
            PROBE_MODE_ANALOG  <= (pmode_q == `DPC_MODE_ANALOG);  // RULE_11
            PROBE_MODE_DIGITAL <= (pmode_q == `DPC_MODE_DIGITAL); // RULE_11
            PROBE_GROUP        <= pgrp_q;
            // Swap only for the exact value 1
            PROBE_LINE_SWAP    <= (pswap_q == 8'h01);             // RULE_13
        end
    end

    // Pad routing entry split and valid flags
    // Entries past the count still split, the valid flag masks them
    genvar gi;
    generate
        for (gi = 0; gi < MAX_PADS; gi = gi + 1) begin : g_pad
            always @(posedge CLOCK) begin
                if (!RESET_N) begin
                    PAD_ENTRY_VALID[gi]      <= 1'b0;
                    PAD_LOCATION[4*gi +: 4]  <= 4'h0;
                    PAD_BIT[4*gi +: 4]       <= 4'h0;
                end else begin
                    PAD_ENTRY_VALID[gi]     <= (pcnt_q > gi);                 // RULE_14
                    PAD_LOCATION[4*gi +: 4] <= PAD_ENTRIES[8*gi+4 +: 4];      // RULE_15
                    PAD_BIT[4*gi +: 4]      <= PAD_ENTRIES[8*gi +: 4];        // RULE_15
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== bench/dpc_bank_props.sv ====
// Concurrent checks on the ports of the delay and probe config bank.
// Assumes one clock and a bind onto every dpc_bank instance.
`timescale 1ns/1ps
`default_nettype none
module dpc_bank_props #(
    parameter MAX_PADS = 4
) (
    input wire logic                  CLOCK,
    input wire logic                  RESET_N,
    input wire logic [7:0]            ADDR,
    input wire logic [7:0]            WDATA,
    input wire logic                  WR,
    input wire logic                  RD,
    input wire logic [7:0]            RDATA,
    input wire logic                  LOAD_VALID,
    input wire logic                  READY,
    input wire logic [1:0]            RATE_A,
    input wire logic                  RATE_F_SLOW,
    input wire logic [8*MAX_PADS-1:0] PAD_ENTRIES,
    input wire logic                  FW_RX_DELAY_ENABLE,
    input wire logic [2:0]            TIMER_ONEHOT,
    input wire logic                  REGULATED_OUT,
    input wire logic [10:0]           DELAY_A,
    input wire logic [10:0]           DELAY_F,
    input wire logic [7:0]            DELAY_I2,
    input wire logic                  PROBE_MODE_ANALOG,
    input wire logic                  PROBE_MODE_DIGITAL,
    input wire logic [7:0]            PROBE_GROUP,
    input wire logic                  PROBE_LINE_SWAP,
    input wire logic [MAX_PADS-1:0]   PAD_ENTRY_VALID,
    input wire logic [4*MAX_PADS-1:0] PAD_LOCATION,
    input wire logic [4*MAX_PADS-1:0] PAD_BIT
);
// ****************************************
// Properties
// ****************************************
default clocking cb @(posedge CLOCK); endclocking
default disable iff (!RESET_N);
// Host write taken by the bank
wire logic hw = READY && WR;
a_delay_enable: assert property (hw && ADDR == 8'hE8 |=> ##1 FW_RX_DELAY_ENABLE == $past(WDATA[0], 2)) else $error("delay enable wrong");
a_timer_select: assert property (hw && ADDR == 8'hE8 |=> ##1 TIMER_ONEHOT == (3'b001 << $past(WDATA[2:1], 2))) else $error("timer select wrong");
a_regulated_out: assert property (hw && ADDR == 8'hE8 |=> ##1 REGULATED_OUT == $past(WDATA[3], 2)) else $error("regulated output wrong");
a_delay_off: assert property (!FW_RX_DELAY_ENABLE |-> DELAY_A == 11'h000 && DELAY_F == 11'h000 && DELAY_I2 == 8'h00) else $error("delay not zero");
a_scale_type_a: assert property ($stable(RATE_A) |-> ((DELAY_A >> RATE_A) << RATE_A) == DELAY_A && (DELAY_A >> (8 + RATE_A)) == 0) else $error("type A scale wrong");
a_scale_type_f: assert property ($stable(RATE_F_SLOW) |-> (DELAY_F >> (8 + RATE_F_SLOW)) == 0 && (!RATE_F_SLOW || !DELAY_F[0])) else $error("type F scale wrong");
a_read_idle: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data outside slot");
a_probe_mode: assert property (hw && ADDR == 8'hF0 |=> ##1 PROBE_MODE_ANALOG == ($past(WDATA, 2) == 8'h01) && PROBE_MODE_DIGITAL == ($past(WDATA, 2) == 8'h02)) else $error("probe mode wrong");
a_group_refuse: assert property (hw && ADDR == 8'hF1 && WDATA == 8'h08 && PROBE_MODE_ANALOG && !$past(WR && ADDR == 8'hF0) |=> ##1 $stable(PROBE_GROUP)) else $error("bad group taken");
a_line_swap: assert property (hw && ADDR == 8'hF2 |=> ##1 PROBE_LINE_SWAP == ($past(WDATA, 2) == 8'h01)) else $error("line swap wrong");
a_pad_valid: assert property (hw && ADDR == 8'hF3 |=> ##1 PAD_ENTRY_VALID[0] == ($past(WDATA, 2) != 0) && PAD_ENTRY_VALID[MAX_PADS-1] == ($past(WDATA, 2) > MAX_PADS - 1)) else $error("pad valid wrong");
a_pad_fields: assert property (PAD_ENTRY_VALID[0] && $stable(PAD_ENTRIES) |-> PAD_LOCATION[3:0] == PAD_ENTRIES[7:4] && PAD_BIT[3:0] == PAD_ENTRIES[3:0]) else $error("pad fields wrong");
a_early_write: assert property (!READY && WR && !LOAD_VALID && ADDR == 8'hE8 |=> ##1 $stable(FW_RX_DELAY_ENABLE)) else $error("write taken before ready");
// Main scenarios reached
c_misc_write: cover property (hw && ADDR == 8'hE8);
c_group_refused: cover property (hw && ADDR == 8'hF1 && WDATA == 8'h08 && PROBE_MODE_ANALOG);
c_read: cover property (RD ##1 RDATA != 8'h00);
endmodule
bind dpc_bank dpc_bank_props #(.MAX_PADS(MAX_PADS)) u_props (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LOAD_VALID(LOAD_VALID),
    .READY(READY), .RATE_A(RATE_A), .RATE_F_SLOW(RATE_F_SLOW), .PAD_ENTRIES(PAD_ENTRIES),
    .FW_RX_DELAY_ENABLE(FW_RX_DELAY_ENABLE), .TIMER_ONEHOT(TIMER_ONEHOT),
    .REGULATED_OUT(REGULATED_OUT), .DELAY_A(DELAY_A), .DELAY_F(DELAY_F), .DELAY_I2(DELAY_I2),
    .PROBE_MODE_ANALOG(PROBE_MODE_ANALOG), .PROBE_MODE_DIGITAL(PROBE_MODE_DIGITAL),
    .PROBE_GROUP(PROBE_GROUP), .PROBE_LINE_SWAP(PROBE_LINE_SWAP),
    .PAD_ENTRY_VALID(PAD_ENTRY_VALID), .PAD_LOCATION(PAD_LOCATION), .PAD_BIT(PAD_BIT));
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the delay and probe config bank.
// Assumes dpc_bank with default parameters and the checker bound to it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
// ****************************************
// Signals and design
// ****************************************
logic        clk, rst_n = 0, wr = 0, rd = 0, ld_v = 0, ld_done = 0, f_slow = 0, v_high = 0;
logic        ready, dly_en, reg_out, an, dg, swap;
logic [1:0]  rate_a = 0, rate_b = 0;
logic [2:0]  tmr;
logic [3:0]  pvalid;
logic [7:0]  addr = 0, wdata = 0, ld_a = 0, ld_d = 0, trim = 0, rdata, agc, grp, d_i2, d_i4;
logic [10:0] d_a, d_b, d_f, d_v;
logic [15:0] ploc, pbit;
logic [31:0] sys = 0, pads = 0;
logic [7:0]  dig [10] = '{8'h00, 8'h01, 8'h10, 8'h1B, 8'h1D, 8'h30, 8'h58, 8'h70, 8'h73, 8'hB9};
logic [7:0]  ana [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0A};
int          mismatches = 0, total_checks = 0;
dpc_bank dut (.CLOCK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .LOAD_VALID(ld_v), .LOAD_ADDR(ld_a), .LOAD_DATA(ld_d), .LOAD_DONE(ld_done),
    .READY(ready), .RATE_A(rate_a), .RATE_B(rate_b), .RATE_F_SLOW(f_slow),
    .RATE_V_HIGH(v_high), .TRIM_STORED(trim), .SYS_SETTINGS(sys), .PAD_ENTRIES(pads),
    .FW_RX_DELAY_ENABLE(dly_en), .TIMER_ONEHOT(tmr), .REGULATED_OUT(reg_out), .AGC_TRIM(agc),
    .DELAY_A(d_a), .DELAY_B(d_b), .DELAY_F(d_f), .DELAY_V(d_v), .DELAY_I2(d_i2),
    .DELAY_I4(d_i4), .PROBE_MODE_ANALOG(an), .PROBE_MODE_DIGITAL(dg), .PROBE_GROUP(grp),
    .PROBE_LINE_SWAP(swap), .PAD_ENTRY_VALID(pvalid), .PAD_LOCATION(ploc), .PAD_BIT(pbit));
// Clock at 100 ns
initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
end
// ****************************************
// Shared tasks
// ****************************************
task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
        mismatches++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
endtask
task automatic rd_b(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
endtask
task automatic settle;
    repeat (2) @(posedge clk);
    #1;
endtask
task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask
// ****************************************
// Scenarios
// ****************************************
task automatic t_load;
    logic [7:0] d;
    chk("ready", ready, 0);
    chk("timer", tmr, 1);
    wr_b(8'hE8, 8'h01);
    @(posedge clk);
    ld_v <= 1'b1;
    ld_a <= 8'hE9;
    ld_d <= 8'h5A;
    @(posedge clk);
    ld_v <= 1'b0;
    ld_done <= 1'b1;
    @(posedge clk);
    ld_done <= 1'b0;
    settle;
    chk("ready", ready, 1);
    chk("early_wr", dly_en, 0);
    rd_b(8'hE9, d);
    chk("load", d, 8'h5A);
endtask
task automatic t_regs;
    logic [7:0] d;
    for (int a = 8'hE9; a <= 8'hF3; a++)
        if (a != 8'hF1) wr_b(a[7:0], a[7:0] ^ 8'h5C);
    for (int a = 8'hE9; a <= 8'hF3; a++) begin
        rd_b(a[7:0], d);
        if (a != 8'hF1) chk("reg", d, a[7:0] ^ 8'h5C);
    end
    wr_b(8'hF4, 8'hFF);
    rd_b(8'hF4, d);
    chk("unmapped", d, 0);
    @(posedge clk);
    #1 chk("rd_idle", rdata, 0);
endtask
task automatic t_misc;
    logic [7:0] m, d;
    @(posedge clk);
    trim <= 8'hF0;
    sys <= 32'h0002_5000;
    for (int i = 0; i < 32; i++) begin
        m = i[7:0];
        wr_b(8'hE8, m);
        settle;
        chk("fw_en", dly_en, m[0]);
        chk("timer", tmr, m[2:1] == 2'b11 ? 3'b000 : 3'b001 << m[2:1]);
        chk("reg_out", reg_out, m[3]);
        chk("agc", agc, m[4] ? 8'h15 : 8'hF0);
        rd_b(8'hE8, d);
        chk("misc", d, m);
    end
endtask
task automatic t_delay;
    wr_b(8'hE9, 8'hC5);
    wr_b(8'hEA, 8'h3A);
    wr_b(8'hEB, 8'h81);
    wr_b(8'hEC, 8'hFF);
    wr_b(8'hED, 8'h5C);
    wr_b(8'hEE, 8'hA3);
    wr_b(8'hE8, 8'h01);
    for (int r = 0; r < 4; r++) begin
        @(posedge clk);
        rate_a <= r[1:0];
        rate_b <= r[1:0];
        f_slow <= r[0];
        v_high <= r[0];
        settle;
        chk("dly_a", d_a, 11'h0C5 << r);
        chk("dly_b", d_b, 11'h03A << r);
        chk("dly_f", d_f, 11'h081 << r[0]);
        chk("dly_v", d_v, 11'h0FF << r[0]);
        chk("dly_i", {d_i2, d_i4}, 16'h5CA3);
    end
    wr_b(8'hE8, 8'h00);
    settle;
    chk("dly_off", {d_a, d_b, d_f, d_v, d_i2, d_i4}, 0);
endtask
task automatic t_probe;
    wr_b(8'hF0, 8'h01);
    for (int i = 0; i < 9; i++) begin
        wr_b(8'hF1, ana[i]);
        wr_b(8'hF1, 8'h08);
        settle;
        chk("grp_ana", grp, ana[i]);
    end
    chk("mode_an", {an, dg}, 2'b10);
    wr_b(8'hF0, 8'h02);
    for (int i = 0; i < 10; i++) begin
        wr_b(8'hF1, dig[i]);
        wr_b(8'hF1, 8'h0A);
        settle;
        chk("grp_dig", grp, dig[i]);
    end
    chk("mode_dg", {an, dg}, 2'b01);
endtask
task automatic t_swap_pad;
    for (int v = 0; v < 3; v++) begin
        wr_b(8'hF2, v[7:0]);
        settle;
        chk("swap", swap, v == 1);
    end
    @(posedge clk);
    pads <= 32'h8771_2C05;
    for (int n = 0; n < 6; n++) begin
        wr_b(8'hF3, n[7:0]);
        settle;
        chk("pad_valid", pvalid, n >= 4 ? 4'hF : (4'h1 << n) - 4'h1);
    end
    chk("pad_loc", ploc, 16'h8720);
    chk("pad_bit", pbit, 16'h71C5);
endtask
// Main sequence and watchdog
initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    settle;
    t_load;
    t_regs;
    t_misc;
    t_delay;
    t_probe;
    t_swap_pad;
    final_report;
end
initial begin
    #2000000;
    mismatches++;
    final_report;
end
endmodule
`default_nettype wire
